// >>> include/rtc_pkg.sv
package rtc_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_SECONDS = 4'h0;
  localparam logic [3:0] ADDR_MINUTES = 4'h1;
  localparam logic [3:0] ADDR_HOURS = 4'h2;
  localparam logic [3:0] ADDR_WEEKDAY = 4'h3;
  localparam logic [3:0] ADDR_MONTHDAY = 4'h4;
  localparam logic [3:0] ADDR_MONTH = 4'h5;
  localparam logic [3:0] ADDR_YEAR = 4'h6;
  localparam logic [3:0] ADDR_TRIM = 4'h7;
  // ---------------------------------------------------------------
  // Implemented bits per register
  // ---------------------------------------------------------------
  localparam logic [7:0] MASK_SECONDS = 8'h7F;
  localparam logic [7:0] MASK_MINUTES = 8'h7F;
  localparam logic [7:0] MASK_HOURS = 8'h3F;
  localparam logic [7:0] MASK_WEEKDAY = 8'h07;
  localparam logic [7:0] MASK_MONTHDAY = 8'h3F;
  localparam logic [7:0] MASK_MONTH = 8'h9F;
  localparam logic [7:0] MASK_TRIM = 8'h7F;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int HOUR_PM_BIT = 5;
  localparam int CENTURY_BIT = 7;
  localparam int TRIM_GUARD_BIT = 7;
  localparam int TRIM_DIR_BIT = 6;
  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_SECONDS = 8'h00;
  localparam logic [7:0] RST_MINUTES = 8'h00;
  localparam logic [7:0] RST_HOURS = 8'h00;
  localparam logic [2:0] RST_WEEKDAY = 3'h0;
  localparam logic [7:0] RST_MONTHDAY = 8'h01;
  localparam logic [7:0] RST_MONTH = 8'h01;
  localparam logic [7:0] RST_YEAR = 8'h00;
  localparam logic [7:0] RST_TRIM = 8'h00;
  // ---------------------------------------------------------------
  // Divider counts and last weekday
  // ---------------------------------------------------------------
  localparam logic [15:0] TICKS_PER_SECOND = 16'h8000;
  localparam logic [15:0] TERM_BASE = 16'h7FFF;
  localparam logic [15:0] TRIM_UP_BIAS = 16'h0002;
  localparam logic [15:0] TRIM_DOWN_BIAS = 16'h0080;
  localparam logic [2:0] WEEKDAY_LAST = 3'h6;

  // BCD increment of a two-digit value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {4'(v[7:4] + 4'h1), 4'h0};
    end
    return {v[7:4], 4'(v[3:0] + 4'h1)};
  endfunction

  function automatic logic is_leap(input logic [7:0] yr);
    if (yr[4]) begin
      return (yr[3:0] == 4'h2) || (yr[3:0] == 4'h6);
    end
    return (yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) || (yr[3:0] == 4'h8);
  endfunction

  function automatic logic [7:0] last_day(input logic [4:0] mon, input logic [7:0] yr);
    if (mon == 5'h02) begin
      return is_leap(yr) ? 8'h29 : 8'h28;
    end
    if (mon == 5'h04 || mon == 5'h06 || mon == 5'h09 || mon == 5'h11) begin
      return 8'h30;
    end
    return 8'h31;
  endfunction

  // Last divider count of a second under the given trim value
  function automatic logic [15:0] trim_term(input logic [7:0] trim);
    if (trim[5:1] == 5'h00) begin
      return TERM_BASE;
    end
    return 16'(TERM_BASE + {9'h000, trim[5:0], 1'b0}
      - (trim[TRIM_DIR_BIT] ? TRIM_DOWN_BIAS : TRIM_UP_BIAS));
  endfunction
endpackage

// >>> include/sec_div_if.sv
interface sec_div_if;
  logic tick;
  logic clear_div;
  logic [15:0] term_cnt;
  logic sec_pulse;
  modport ctrl (output tick, output clear_div, output term_cnt, input sec_pulse);
  modport div (input tick, input clear_div, input term_cnt, output sec_pulse);
endinterface

// >>> hdl/sec_divider.sv
module sec_divider
  import rtc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  sec_div_if.div dv
);
  logic [15:0] cnt_ff;
  logic pulse_ff;

  always_ff @(posedge ref_clk) begin
    if (srst || dv.clear_div) begin
      cnt_ff <= 16'h0000;
    end else if (dv.tick) begin
      cnt_ff <= (cnt_ff >= dv.term_cnt) ? 16'h0000 : 16'(cnt_ff + 16'h0001);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pulse_ff <= 1'b0;
    end else begin
      pulse_ff <= dv.tick && !dv.clear_div && (cnt_ff >= dv.term_cnt);
    end
  end

  assign dv.sec_pulse = pulse_ff;

  div_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
    dv.clear_div |=> (cnt_ff == 16'h0000) && !pulse_ff)
    else $error("divider not cleared by seconds write");
endmodule // sec_divider

// >>> hdl/weekday_counter.sv
module weekday_counter
  import rtc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic day_carry,
  input wire logic wr_en,
  input wire logic [2:0] wr_data,
  output logic [2:0] weekday
);
  logic [2:0] weekday_ff;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      weekday_ff <= RST_WEEKDAY;
    end else if (wr_en) begin
      weekday_ff <= wr_data;
    end else if (day_carry) begin
      weekday_ff <= (weekday_ff == WEEKDAY_LAST) ? 3'h0 : 3'(weekday_ff + 3'h1);
    end
  end

  assign weekday = weekday_ff;

  weekday_wrap_a: assert property (@(posedge ref_clk) disable iff (srst)
    day_carry && !wr_en && weekday_ff == WEEKDAY_LAST |=> weekday_ff == 3'h0)
    else $error("weekday did not wrap after six");
  weekday_step_a: assert property (@(posedge ref_clk) disable iff (srst)
    day_carry && !wr_en && weekday_ff < WEEKDAY_LAST |=> weekday_ff == $past(weekday_ff) + 3'h1)
    else $error("weekday did not advance with day carry");
endmodule // weekday_counter

// >>> hdl/rtc_timekeeper.sv
module rtc_timekeeper
  import rtc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic xtal_tick,
  input wire logic osc_halt_flag,
  input wire logic mode_24h,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_ff
);
  // ---------------------------------------------------------------
  // Counter state
  // ---------------------------------------------------------------
  logic [7:0] seconds_ff;
  logic [7:0] minutes_ff;
  logic [7:0] hours_ff;
  logic [7:0] monthday_ff;
  logic [4:0] month_ff;
  logic century_ff;
  logic [7:0] year_ff;
  logic [7:0] trim_ff;
  logic trim_active_ff;
  logic trim_written_ff;
  logic [2:0] weekday;

  logic wr_sec;
  logic wr_min;
  logic wr_hour;
  logic wr_wday;
  logic wr_mday;
  logic wr_month;
  logic wr_year;
  logic wr_trim;
  logic sec_pulse;
  logic sec_carry;
  logic min_carry;
  logic day_carry;
  logic month_carry;
  logic year_carry;
  logic century_carry;
  logic adjust_second;
  logic [7:0] nxt_hours;
  logic hour_carry;
  logic [7:0] nxt_rdata;

  sec_div_if div_bus ();

  // ---------------------------------------------------------------
  // Register write decode
  // ---------------------------------------------------------------
  always_comb begin
    wr_sec = 1'b0;
    wr_min = 1'b0;
    wr_hour = 1'b0;
    wr_wday = 1'b0;
    wr_mday = 1'b0;
    wr_month = 1'b0;
    wr_year = 1'b0;
    wr_trim = 1'b0;
    if (!reg_wr) begin
      wr_sec = 1'b0;
    end else if (reg_addr == ADDR_SECONDS) begin
      wr_sec = 1'b1;
    end else if (reg_addr == ADDR_MINUTES) begin
      wr_min = 1'b1;
    end else if (reg_addr == ADDR_HOURS) begin
      wr_hour = 1'b1;
    end else if (reg_addr == ADDR_WEEKDAY) begin
      wr_wday = 1'b1;
    end else if (reg_addr == ADDR_MONTHDAY) begin
      wr_mday = 1'b1;
    end else if (reg_addr == ADDR_MONTH) begin
      wr_month = 1'b1;
    end else if (reg_addr == ADDR_YEAR) begin
      wr_year = 1'b1;
    end else if (reg_addr == ADDR_TRIM) begin
      wr_trim = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Hour stepping in both modes
  // ---------------------------------------------------------------
  always_comb begin
    hour_carry = 1'b0;
    nxt_hours = bcd_inc(hours_ff);
    if (mode_24h) begin
      if (hours_ff == 8'h23) begin
        nxt_hours = 8'h00;
        hour_carry = 1'b1;
      end
    end else begin
      if (hours_ff[4:0] == 5'h11) begin
        nxt_hours = {2'b00, !hours_ff[HOUR_PM_BIT], 5'h12};
        hour_carry = hours_ff[HOUR_PM_BIT];
      end else if (hours_ff[4:0] == 5'h12) begin
        nxt_hours = {2'b00, hours_ff[HOUR_PM_BIT], 5'h01};
      end else begin
        nxt_hours = {2'b00, hours_ff[HOUR_PM_BIT], 5'(bcd_inc({3'h0, hours_ff[4:0]}))};
      end
    end
  end

  // ---------------------------------------------------------------
  // Carry chain
  // ---------------------------------------------------------------
  assign sec_pulse = div_bus.sec_pulse;
  assign sec_carry = sec_pulse && (seconds_ff == 8'h59);
  assign min_carry = sec_carry && (minutes_ff == 8'h59);
  assign day_carry = min_carry && hour_carry;
  assign month_carry = day_carry && (monthday_ff == last_day(month_ff, year_ff));
  assign year_carry = month_carry && (month_ff == 5'h12);
  assign century_carry = year_carry && (year_ff == 8'h99);

  // ---------------------------------------------------------------
  // Time counters
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      seconds_ff <= RST_SECONDS;
    end else if (wr_sec) begin
      seconds_ff <= reg_wdata & MASK_SECONDS;
    end else if (sec_pulse) begin
      seconds_ff <= sec_carry ? 8'h00 : bcd_inc(seconds_ff);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      minutes_ff <= RST_MINUTES;
    end else if (wr_min) begin
      minutes_ff <= reg_wdata & MASK_MINUTES;
    end else if (sec_carry) begin
      minutes_ff <= min_carry ? 8'h00 : bcd_inc(minutes_ff);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hours_ff <= RST_HOURS;
    end else if (wr_hour) begin
      hours_ff <= reg_wdata & MASK_HOURS;
    end else if (min_carry) begin
      hours_ff <= nxt_hours;
    end
  end

  // ---------------------------------------------------------------
  // Calendar counters
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      monthday_ff <= RST_MONTHDAY;
    end else if (wr_mday) begin
      monthday_ff <= reg_wdata & MASK_MONTHDAY;
    end else if (day_carry) begin
      monthday_ff <= month_carry ? 8'h01 : bcd_inc(monthday_ff);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      month_ff <= RST_MONTH[4:0];
    end else if (wr_month) begin
      month_ff <= reg_wdata[4:0];
    end else if (month_carry) begin
      month_ff <= year_carry ? 5'h01 : 5'(bcd_inc({3'h0, month_ff}));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      century_ff <= RST_MONTH[CENTURY_BIT];
    end else if (wr_month) begin
      century_ff <= reg_wdata[CENTURY_BIT];
    end else if (century_carry) begin
      century_ff <= !century_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      year_ff <= RST_YEAR;
    end else if (wr_year) begin
      year_ff <= reg_wdata;
    end else if (year_carry) begin
      year_ff <= century_carry ? 8'h00 : bcd_inc(year_ff);
    end
  end

  weekday_counter u_weekday (
    .ref_clk(ref_clk),
    .srst(srst),
    .day_carry(day_carry),
    .wr_en(wr_wday),
    .wr_data(reg_wdata[2:0]),
    .weekday(weekday)
  );

  // ---------------------------------------------------------------
  // Rate trim
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst || osc_halt_flag) begin
      trim_ff <= RST_TRIM;
    end else if (wr_trim && !reg_wdata[TRIM_GUARD_BIT]) begin
      trim_ff <= reg_wdata & MASK_TRIM;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || osc_halt_flag) begin
      trim_active_ff <= 1'b0;
    end else if (wr_trim && !reg_wdata[TRIM_GUARD_BIT]) begin
      trim_active_ff <= 1'b1;
    end
  end

  // Write seen within the current second blocks its adjustment
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      trim_written_ff <= 1'b0;
    end else if (wr_trim && !reg_wdata[TRIM_GUARD_BIT]) begin
      trim_written_ff <= 1'b1;
    end else if (sec_pulse || wr_sec) begin
      trim_written_ff <= 1'b0;
    end
  end

  assign adjust_second = trim_active_ff && !trim_written_ff
    && (seconds_ff == 8'h00 || seconds_ff == 8'h20 || seconds_ff == 8'h40);

  // Crystal tick passes through untouched; only the terminal count moves
  assign div_bus.tick = xtal_tick;
  assign div_bus.clear_div = wr_sec;
  assign div_bus.term_cnt = adjust_second ? trim_term(trim_ff) : TERM_BASE;

  sec_divider u_divider (
    .ref_clk(ref_clk),
    .srst(srst),
    .dv(div_bus)
  );

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_addr == ADDR_SECONDS) begin
      nxt_rdata = seconds_ff & MASK_SECONDS;
    end else if (reg_addr == ADDR_MINUTES) begin
      nxt_rdata = minutes_ff & MASK_MINUTES;
    end else if (reg_addr == ADDR_HOURS) begin
      nxt_rdata = hours_ff & MASK_HOURS;
    end else if (reg_addr == ADDR_WEEKDAY) begin
      nxt_rdata = {5'h00, weekday};
    end else if (reg_addr == ADDR_MONTHDAY) begin
      nxt_rdata = monthday_ff & MASK_MONTHDAY;
    end else if (reg_addr == ADDR_MONTH) begin
      nxt_rdata = {century_ff, 2'b00, month_ff};
    end else if (reg_addr == ADDR_YEAR) begin
      nxt_rdata = year_ff;
    end else if (reg_addr == ADDR_TRIM) begin
      nxt_rdata = trim_ff & MASK_TRIM;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  minute_wrap_a: assert property (
    min_carry && !wr_min && !wr_hour |=> minutes_ff == 8'h00 && hours_ff == $past(nxt_hours))
    else $error("minute wrap did not carry into hours");
  hour_day_a: assert property (
    day_carry |-> (mode_24h ? hours_ff == 8'h23 : hours_ff == 8'h31) && minutes_ff == 8'h59)
    else $error("day carry at wrong hour");
  month_end_a: assert property (
    month_carry |-> monthday_ff == (month_ff == 5'h02 ? (is_leap(year_ff) ? 8'h29 : 8'h28)
      : ((month_ff == 5'h04 || month_ff == 5'h06 || month_ff == 5'h09 || month_ff == 5'h11)
      ? 8'h30 : 8'h31)))
    else $error("month ended on wrong day");
  day_restart_a: assert property (
    month_carry && !wr_mday && !wr_month |=> monthday_ff == 8'h01
      && month_ff == ($past(month_ff) == 5'h12 ? 5'h01 : 5'($past(bcd_inc({3'h0, month_ff})))))
    else $error("day or month did not restart");
  century_flip_a: assert property (
    century_carry && !wr_month && !wr_year |=> year_ff == 8'h00 && century_ff != $past(century_ff))
    else $error("century bit did not toggle");
  trim_halt_a: assert property (
    osc_halt_flag |=> trim_ff == 8'h00 && !trim_active_ff)
    else $error("halt did not clear trim");
  trim_guard_a: assert property (
    wr_trim && reg_wdata[TRIM_GUARD_BIT] && !osc_halt_flag |=> $stable(trim_ff))
    else $error("guarded trim write took effect");
  trim_flat_a: assert property (
    trim_ff[5:1] == 5'h00 |-> div_bus.term_cnt == TERM_BASE)
    else $error("trim changed count with zero magnitude");
  trim_skip_a: assert property (
    wr_trim && !reg_wdata[TRIM_GUARD_BIT] && !sec_pulse && !osc_halt_flag
      |=> div_bus.term_cnt == TERM_BASE)
    else $error("adjustment applied in second of trim write");
  trim_window_a: assert property (
    div_bus.term_cnt != TERM_BASE
      |-> seconds_ff == 8'h00 || seconds_ff == 8'h20 || seconds_ff == 8'h40)
    else $error("trim outside adjusting seconds");
  unused_zero_a: assert property (
    reg_rd && reg_addr > ADDR_TRIM |=> reg_rdata_ff == 8'h00)
    else $error("unmapped read not zero");

  year_roll_c: cover property (century_carry);
  leap_feb_c: cover property (month_carry && month_ff == 5'h02 && monthday_ff == 8'h29);
  trim_used_c: cover property (sec_pulse && div_bus.term_cnt != TERM_BASE);
  pm_day_c: cover property (day_carry && !mode_24h);
endmodule // rtc_timekeeper

// >>> tb/host_model.sv
module host_model (
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata_ff,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic xtal_tick
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    xtal_tick = 1'b0;
  end

  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  // Callers pass real dates and weekdays 0 to 6; one trim write (8'h85) sets the guard bit
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    // Released bus no longer shows the last value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(posedge ref_clk);
    #1;
    d = reg_rdata_ff;
  endtask

  // ---------------------------------------------------------------
  // Crystal ticks, two cycles apart
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      xtal_tick = 1'b1;
      @(posedge ref_clk);
      #1;
      xtal_tick = 1'b0;
    end
  endtask
endmodule // host_model

// >>> tb/tb_rtc_timekeeper.sv
module tb_rtc_timekeeper
  import rtc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic osc_halt_flag = 1'b0;
  logic mode_24h = 1'b1;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic xtal_tick;
  logic [7:0] reg_rdata_ff;
  logic [31:0] lfsr = 32'h1f47_0f95;
  int err_count = 0;
  int checks_done = 0;
  int tl [1:6] = '{6, 2, 1, 3, 1, 10};
  int ul [1:6] = '{10, 10, 7, 9, 9, 10};
  int uo [1:6] = '{0, 0, 0, 1, 1, 0};
  logic [7:0] msk [1:6] = '{MASK_MINUTES, MASK_HOURS, MASK_WEEKDAY, MASK_MONTHDAY,
    MASK_MONTH, 8'hFF};
  logic [7:0] start_v [0:6] = '{8'h59, 8'h59, 8'h23, 8'h06, 8'h31, 8'h12, 8'h99};
  logic [7:0] after_v [0:6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h81, 8'h00};

  always #4 ref_clk = ~ref_clk;

  rtc_timekeeper rtc_timekeeper_i (
    .ref_clk(ref_clk), .srst(srst), .xtal_tick(xtal_tick), .osc_halt_flag(osc_halt_flag),
    .mode_24h(mode_24h), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff)
  );

  host_model host_model_i (
    .ref_clk(ref_clk), .reg_rdata_ff(reg_rdata_ff), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .xtal_tick(xtal_tick)
  );

  // ---------------------------------------------------------------
  // Expectations and checking
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic int exp_ticks(input logic [7:0] t);
    logic [5:0] m;
    m = t[5:0];
    if (t[5:1] == 5'h00) return 32768;
    if (t[6]) return 32768 - 2 * (int'(6'(~m)) + 1);
    return 32768 + 2 * (int'(m) - 1);
  endfunction

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string name);
    logic [7:0] d;
    host_model_i.rd(a, d);
    chk(name, exp, d);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] v;
    int a;
    repeat (2) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    rd_chk(ADDR_TRIM, 8'h00, "trim reset");
    // Random legal values with junk in unused bits
    for (int i = 0; i < 12; i++) begin
      lfsr = lfsr_next(lfsr);
      a = i % 6 + 1;
      v = {4'(lfsr[3:0] % tl[a]), 4'(lfsr[7:4] % ul[a] + uo[a])};
      host_model_i.wr(4'(a), v | (lfsr[15:8] & ~msk[a]));
      rd_chk(4'(a), v, "readback");
    end
    // Trim write, halt clear, refused writes
    host_model_i.wr(ADDR_TRIM, 8'h55);
    rd_chk(ADDR_TRIM, 8'h55, "trim write");
    // Guarded write must leave the live value in place
    host_model_i.wr(ADDR_TRIM, 8'h85);
    rd_chk(ADDR_TRIM, 8'h55, "trim guard bit");
    @(posedge ref_clk);
    #1;
    osc_halt_flag = 1'b1;
    host_model_i.wr(ADDR_TRIM, 8'h2A);
    @(posedge ref_clk);
    #1;
    osc_halt_flag = 1'b0;
    rd_chk(ADDR_TRIM, 8'h00, "trim after halt");
    rd_chk(4'hA, 8'h00, "unmapped");
    // Twelve-hour mode keeps the afternoon flag in bit 5
    mode_24h = 1'b0;
    host_model_i.wr(ADDR_HOURS, 8'h32 | (lfsr[23:16] & ~MASK_HOURS));
    rd_chk(ADDR_HOURS, 8'h32, "hours pm");
    host_model_i.wr(ADDR_HOURS, 8'h11);
    rd_chk(ADDR_HOURS, 8'h11, "hours am");
    mode_24h = 1'b1;
    // Full carry chain on the last second of a century
    for (int i = 0; i < 7; i++) host_model_i.wr(4'(i), start_v[i]);
    host_model_i.tick(100);
    host_model_i.wr(ADDR_SECONDS, 8'h59);
    host_model_i.tick(32767);
    repeat (4) @(posedge ref_clk);
    rd_chk(ADDR_SECONDS, 8'h59, "divider cleared");
    host_model_i.tick(1);
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 7; i++) begin
      rd_chk(4'(i), after_v[i], "rollover");
    end
    // Shortened second at second 00
    host_model_i.wr(ADDR_TRIM, 8'h7E);
    host_model_i.wr(ADDR_SECONDS, 8'h00);
    host_model_i.tick(exp_ticks(8'h7E) - 1);
    repeat (4) @(posedge ref_clk);
    rd_chk(ADDR_SECONDS, 8'h00, "trim early");
    host_model_i.tick(1);
    repeat (4) @(posedge ref_clk);
    rd_chk(ADDR_SECONDS, 8'h01, "trim second");
    stop_test();
  end

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  initial begin
    #1_400_000;
    err_count++;
    stop_test();
  end
endmodule // tb_rtc_timekeeper
